/* hdl/ccr_config_regs.sv */
// Control channel configuration registers with sync filter and channel watchdog
//
// Behaviour
// - General config bit 6 enables back-channel CRC generation; enabled after reset.
// - General config bit 5 picks pull-down when set, pull-up when clear; pull-down default.
// - Bit 4 set drops sync/enable pulses shorter than two pixel clocks; set at reset.
// - Bit 3 forwards I2C transactions matching an alias to the remote serializer.
// - Bit 2 acknowledges I2C transactions regardless of link lock; off at reset.
// - Watchdog aborts an unfinished channel transaction after field times 2 ms; a zero field counts as one.
// - Watchdog control bit 0 set stops the watchdog; running after reset.
// - Serial bus control bit 7 forwards every local I2C transaction; off at reset.
// - Three-bit field sets I2C data hold time after clock in 50 ns steps.
// - Four-bit field sets widest rejected I2C glitch in 5 ns steps.
`timescale 1ns/1ps
`include "ccr_params.svh"
module ccr_config_regs #(
   parameter int unsigned WD_STEP_CYC = `CCR_WD_STEP_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // Register port, from the local serial control bus slave
   input wire logic regWrEn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   // Pixel-rate sync inputs, one enable per pixel clock
   input wire logic pixelEn,
   input wire logic dataEnableIn,
   input wire logic horizontalSyncIn,
   input wire logic verticalSyncIn,
   output logic dataEnableOut,
   output logic horizontalSyncOut,
   output logic verticalSyncOut,
   // Local I2C transaction classification
   input wire logic txnStart,
   input wire logic txnDone,
   input wire logic aliasMatch,
   output logic forwardRemote,
   // Control channel watchdog
   output logic channelAbort,
   output logic channelBusy,
   // Configuration outputs
   output logic crcGenEnable,
   output logic pullDownSel,
   output logic autoAck,
   output logic [6:0] sdaHoldSteps,
   output logic [3:0] glitchDepthSteps
);

   ccr_pkg::ccr_byte_t genCfg_ff, nxt_genCfg;
   ccr_pkg::ccr_byte_t wdCfg_ff, nxt_wdCfg;
   ccr_pkg::ccr_byte_t sbCfg_ff, nxt_sbCfg;

   // Register writes; reserved bits of general config are held at default
   always_comb begin
      nxt_genCfg = genCfg_ff;
      nxt_wdCfg = wdCfg_ff;
      nxt_sbCfg = sbCfg_ff;
      if (regWrEn) begin
         case (regAddr)
            `CCR_OFF_GEN_CFG: nxt_genCfg = (regWrData & ~`CCR_GEN_RSVD_MASK) |
                                           (`CCR_RST_GEN_CFG & `CCR_GEN_RSVD_MASK);
            `CCR_OFF_WDOG: nxt_wdCfg = regWrData;
            `CCR_OFF_SBUS: nxt_sbCfg = regWrData;
            default: nxt_genCfg = genCfg_ff;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         genCfg_ff <= `CCR_RST_GEN_CFG;
         wdCfg_ff <= `CCR_RST_WDOG;
         sbCfg_ff <= `CCR_RST_SBUS;
      end else begin
         genCfg_ff <= nxt_genCfg;
         wdCfg_ff <= nxt_wdCfg;
         sbCfg_ff <= nxt_sbCfg;
      end
   end

   // Unlisted addresses read zero
   always_comb begin
      case (regAddr)
         `CCR_OFF_GEN_CFG: regRdData = genCfg_ff;
         `CCR_OFF_WDOG: regRdData = wdCfg_ff;
         `CCR_OFF_SBUS: regRdData = sbCfg_ff;
         default: regRdData = 8'h00;
      endcase
   end

   assign crcGenEnable = genCfg_ff[`CCR_BIT_CRC];
   assign pullDownSel = genCfg_ff[`CCR_BIT_PULL];
   assign autoAck = genCfg_ff[`CCR_BIT_ACK];
   // Hold in 50 ns steps; at 100 MHz each step is whole cycles
   assign sdaHoldSteps = 7'(sbCfg_ff[6:4] * `CCR_HOLD_STEP_CYC);
   // Steps finer than one clock; passed on as raw 5 ns steps to the pad filter
   assign glitchDepthSteps = sbCfg_ff[3:0];
   // Pass-all overrides alias matching
   assign forwardRemote = sbCfg_ff[`CCR_BIT_PASSALL] |
                          (genCfg_ff[`CCR_BIT_PASS] & aliasMatch);

   // Two-pixel sync filter: a level is taken only once stable for two pixels
   logic [2:0] syncIn, syncOut_ff, nxt_syncOut, syncPrev_ff, nxt_syncPrev;
   assign syncIn = {verticalSyncIn, horizontalSyncIn, dataEnableIn};

   always_comb begin
      nxt_syncOut = syncOut_ff;
      nxt_syncPrev = syncPrev_ff;
      if (!genCfg_ff[`CCR_BIT_FILT]) begin
         nxt_syncOut = syncIn;
         nxt_syncPrev = syncIn;
      end else if (pixelEn) begin
         nxt_syncPrev = syncIn;
         for (int i = 0; i < 3; i++) begin
            // A one-pixel pulse never matches its neighbour sample
            if (syncIn[i] == syncPrev_ff[i])
               nxt_syncOut[i] = syncIn[i];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         syncOut_ff <= 3'h0;
         syncPrev_ff <= 3'h0;
      end else begin
         syncOut_ff <= nxt_syncOut;
         syncPrev_ff <= nxt_syncPrev;
      end
   end
   assign {verticalSyncOut, horizontalSyncOut, dataEnableOut} = syncOut_ff;

   // Watchdog: step divider plus step counter, one transaction at a time
   ccr_pkg::ccr_state_e state_ff, nxt_state;
   logic [31:0] divCnt_ff, nxt_divCnt;
   logic [6:0] stepCnt_ff, nxt_stepCnt;
   logic stepTick;
   assign stepTick = (divCnt_ff == WD_STEP_CYC - 1);

   always_comb begin
      nxt_state = state_ff;
      nxt_divCnt = divCnt_ff;
      nxt_stepCnt = stepCnt_ff;
      case (state_ff)
         ccr_pkg::CCR_IDLE: begin
            nxt_divCnt = 32'h0;
            nxt_stepCnt = 7'h00;
            if (txnStart && !txnDone)
               nxt_state = ccr_pkg::CCR_BUSY;
         end
         ccr_pkg::CCR_BUSY: begin
            nxt_divCnt = stepTick ? 32'h0 : divCnt_ff + 32'h1;
            if (stepTick)
               nxt_stepCnt = stepCnt_ff + 7'h01;
            if (txnDone)
               nxt_state = ccr_pkg::CCR_IDLE;
            else if (!wdCfg_ff[`CCR_BIT_WDOFF] && stepTick &&
                     (stepCnt_ff + 7'h01 >= wdCfg_ff[7:1]))
               nxt_state = ccr_pkg::CCR_ABORT;
         end
         ccr_pkg::CCR_ABORT: nxt_state = ccr_pkg::CCR_IDLE;
         default: nxt_state = ccr_pkg::CCR_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_ff <= ccr_pkg::CCR_IDLE;
         divCnt_ff <= 32'h0;
         stepCnt_ff <= 7'h00;
      end else begin
         state_ff <= nxt_state;
         divCnt_ff <= nxt_divCnt;
         stepCnt_ff <= nxt_stepCnt;
      end
   end
   assign channelAbort = (state_ff == ccr_pkg::CCR_ABORT);
   assign channelBusy = (state_ff == ccr_pkg::CCR_BUSY);

   // Assertions
   sequence s_expire;
      channelBusy && !txnDone && stepTick && !wdCfg_ff[0] &&
         (stepCnt_ff + 7'h01 >= wdCfg_ff[7:1]);
   endsequence
   AST_ABORT_ON_EXPIRE: assert property (@(posedge clk) disable iff (!arst_n)
      s_expire |=> channelAbort) else $error("watchdog did not abort");
   AST_NO_ABORT_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      channelBusy && wdCfg_ff[0] |=> !channelAbort) else $error("abort while disabled");
   AST_ABORT_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
      channelAbort |=> state_ff == ccr_pkg::CCR_IDLE && !channelAbort)
      else $error("abort not back to idle");
   AST_CRC_BIT: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && regAddr == 8'h03 |=> crcGenEnable == $past(regWrData[6]))
      else $error("crc enable mismatch");
   AST_PULL_BIT: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && regAddr == 8'h03 |=> pullDownSel == $past(regWrData[5]))
      else $error("pull select mismatch");
   AST_FILTER_GLITCH: assert property (@(posedge clk) disable iff (!arst_n)
      genCfg_ff[4] && pixelEn && $stable(genCfg_ff) && dataEnableIn != syncPrev_ff[0]
      |=> dataEnableOut == $past(dataEnableOut)) else $error("short pulse passed");
   AST_PASS_ALIAS: assert property (@(posedge clk) disable iff (!arst_n)
      genCfg_ff[3] && aliasMatch |-> forwardRemote) else $error("alias not forwarded");
   AST_PASS_ALL: assert property (@(posedge clk) disable iff (!arst_n)
      sbCfg_ff[7] |-> forwardRemote) else $error("pass-all not forwarded");
   AST_AUTO_ACK: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && regAddr == 8'h03 |=> autoAck == $past(regWrData[2]))
      else $error("auto ack mismatch");
   AST_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
      sdaHoldSteps == 7'(sbCfg_ff[6:4] * 5)) else $error("hold steps wrong");
   AST_GLITCH_DEPTH: assert property (@(posedge clk) disable iff (!arst_n)
      regWrEn && regAddr == 8'h05 |=> glitchDepthSteps == $past(regWrData[3:0]))
      else $error("glitch depth mismatch");
   AST_NO_FORWARD: assert property (@(posedge clk) disable iff (!arst_n)
      !sbCfg_ff[7] && !genCfg_ff[3] |-> !forwardRemote) else $error("forward while disabled");
   AST_FILTER_OFF: assert property (@(posedge clk) disable iff (!arst_n)
      !genCfg_ff[4] |=> syncOut_ff == $past(syncIn)) else $error("unfiltered level lost");
   AST_START_BUSY: assert property (@(posedge clk) disable iff (!arst_n)
      state_ff == ccr_pkg::CCR_IDLE && txnStart && !txnDone |=> channelBusy)
      else $error("start not taken");
endmodule

/* hdl/ccr_params.svh */
// Offsets, field positions, reset values and timing counts of the control channel config bank
`ifndef CCR_PARAMS_SVH
`define CCR_PARAMS_SVH
`define CCR_OFF_GEN_CFG 8'h03
`define CCR_OFF_WDOG 8'h04
`define CCR_OFF_SBUS 8'h05
`define CCR_RST_GEN_CFG 8'hf0
`define CCR_RST_WDOG 8'hfe
`define CCR_RST_SBUS 8'h1e
`define CCR_GEN_RSVD_MASK 8'h83
`define CCR_BIT_CRC 6
`define CCR_BIT_PULL 5
`define CCR_BIT_FILT 4
`define CCR_BIT_PASS 3
`define CCR_BIT_ACK 2
`define CCR_BIT_WDOFF 0
`define CCR_BIT_PASSALL 7
`define CCR_WD_STEP_MS 2
`define CCR_CLK_MHZ 100
`define CCR_WD_STEP_CYC (`CCR_WD_STEP_MS * 1000 * `CCR_CLK_MHZ)
`define CCR_HOLD_STEP_NS 50
`define CCR_HOLD_STEP_CYC ((`CCR_HOLD_STEP_NS * `CCR_CLK_MHZ) / 1000)
`define CCR_FILT_STEP_NS 5
`define CCR_SYNC_MIN_CYC 2
`endif

/* hdl/ccr_pkg.sv */
// Types of the control channel config bank
package ccr_pkg;
   typedef enum logic [1:0] {
      CCR_IDLE = 2'b00,
      CCR_BUSY = 2'b01,
      CCR_ABORT = 2'b11
   } ccr_state_e;
   typedef logic [7:0] ccr_byte_t;
endpackage

/* tb/ccr_config_regs_tb.sv */
// Self-checking bench of the control channel config bank
`timescale 1ns/1ps
module ccr_config_regs_tb;
   logic clk, arst_n, regWrEn, pixelEn, go, matchIn, txnStart, txnDone, aliasMatch;
   logic fwd, abort, busy, crc, pull, ack, slowPix, busySeen;
   logic [2:0] syncIn, syncOut;
   logic [7:0] regAddr, regWrData, regRdData;
   logic [15:0] lenCyc;
   logic [6:0] hold;
   logic [3:0] glitch;
   int err_total = 0;
   int total_checks = 0;
   int n;
   // Reserved bits stay at default and the timeout field is never zero
   logic [23:0] rows [7] = '{24'h03_80_80, 24'h03_fc_fc, 24'h04_02_02, 24'h04_ff_ff,
      24'h05_ff_ff, 24'h05_00_00, 24'h07_00_00};
   ccr_config_regs #(.WD_STEP_CYC(10)) dut (.clk(clk), .arst_n(arst_n), .regWrEn(regWrEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .pixelEn(pixelEn),
      .dataEnableIn(syncIn[2]), .horizontalSyncIn(syncIn[1]), .verticalSyncIn(syncIn[0]),
      .dataEnableOut(syncOut[2]), .horizontalSyncOut(syncOut[1]),
      .verticalSyncOut(syncOut[0]), .txnStart(txnStart), .txnDone(txnDone),
      .aliasMatch(aliasMatch), .forwardRemote(fwd), .channelAbort(abort),
      .channelBusy(busy), .crcGenEnable(crc), .pullDownSel(pull), .autoAck(ack),
      .sdaHoldSteps(hold), .glitchDepthSteps(glitch));
   ccr_txn_model partner (.clk(clk), .go(go), .lenCyc(lenCyc), .matchIn(matchIn),
      .txnStart(txnStart), .txnDone(txnDone), .aliasMatch(aliasMatch));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Slow pixel rate: one enable every other clock
   always @(negedge clk)
      pixelEn <= slowPix ? ~pixelEn : 1'b1;
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge clk);
      regWrEn = 1'b0;
   endtask
   // Width in clocks: width 1 must vanish when filtering, width 2 must pass at the full pixel rate
   task automatic pulse(input int w, input logic [7:0] exp);
      logic [7:0] seen;
      seen = 8'h00;
      syncIn = 3'b111;
      repeat (w) @(negedge clk);
      syncIn = 3'b000;
      repeat (4) begin
         seen = seen | {5'h00, syncOut};
         @(negedge clk);
      end
      chk(seen, exp);
   endtask
   // Counts edges from the start edge until the abort pulse, 60 if none
   task automatic txn(input logic [15:0] len, input logic m, output int cyc);
      lenCyc = len;
      matchIn = m;
      go = 1'b1;
      @(posedge txnStart);
      @(posedge clk);
      go = 1'b0;
      cyc = 0;
      busySeen = 1'b0;
      while (abort !== 1'b1 && cyc < 60) begin
         @(posedge clk);
         #1;
         busySeen = busySeen | busy;
         cyc++;
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #20000;
      err_total++;
      test_done();
   end
   initial begin
      {arst_n, regWrEn, go, matchIn, slowPix, syncIn, regAddr, regWrData, lenCyc} = '0;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      foreach (rows[i]) begin
         regAddr = rows[i][23:16];
         #1;
         chk(regRdData, (i < 2) ? 8'hf0 : (i < 4) ? 8'hfe : (i < 6) ? 8'h1e : 8'h00);
      end
      chk({3'b000, crc, pull, ack, fwd, busy}, 8'h18);
      chk({1'b0, hold}, 8'h05);
      chk({4'h0, glitch}, 8'h0e);
      $display("reset test done");
      foreach (rows[i]) begin
         if (rows[i][23:16] != 8'h07)
            wr(rows[i][23:16], rows[i][15:8]);
         regAddr = rows[i][23:16];
         #1;
         chk(regRdData, rows[i][7:0]);
      end
      wr(8'h03, 8'hc4);
      chk({5'h00, crc, pull, ack}, 8'h05);
      wr(8'h05, 8'h3a);
      chk({1'b0, hold}, 8'h0f);
      chk({4'h0, glitch}, 8'h0a);
      $display("register test done");
      wr(8'h03, 8'h90);
      pulse(1, 8'h00);
      pulse(2, 8'h07);
      slowPix = 1'b1;
      pulse(2, 8'h00);
      pulse(4, 8'h07);
      slowPix = 1'b0;
      wr(8'h03, 8'h80);
      pulse(1, 8'h07);
      $display("filter test done");
      wr(8'h04, 8'h04);
      txn(16'h0000, 1'b0, n);
      chk(n[7:0], 8'd20);
      wr(8'h03, 8'h88);
      txn(16'h0005, 1'b1, n);
      chk(n[7:0], 8'd60);
      chk({7'h00, busySeen}, 8'h01);
      chk({7'h00, fwd}, 8'h01);
      txn(16'h0005, 1'b0, n);
      chk({7'h00, fwd}, 8'h00);
      wr(8'h05, 8'h80);
      chk({7'h00, fwd}, 8'h01);
      wr(8'h04, 8'h05);
      txn(16'h0000, 1'b0, n);
      chk(n[7:0], 8'd60);
      chk({7'h00, busy}, 8'h01);
      $display("watchdog test done");
      @(negedge clk);
      arst_n = 1'b0;
      regAddr = 8'h04;
      #1;
      chk(regRdData, 8'hfe);
      chk({7'h00, busy}, 8'h00);
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      regAddr = 8'h05;
      #1;
      chk(regRdData, 8'h1e);
      chk({7'h00, fwd}, 8'h00);
      $display("mid-run reset test done");
      test_done();
   end
endmodule

/* tb/ccr_txn_model.sv */
// Local serial host model issuing control channel transactions
`timescale 1ns/1ps
module ccr_txn_model (
   // Clock
   input wire logic clk,
   // Command from the bench
   input wire logic go,
   input wire logic [15:0] lenCyc,
   input wire logic matchIn,
   // Transaction side
   output logic txnStart,
   output logic txnDone,
   output logic aliasMatch
);
   initial begin
      txnStart = 1'b0;
      txnDone = 1'b0;
      aliasMatch = 1'b0;
   end
   // Zero length never finishes, so only the watchdog or a reset can end it
   always @(posedge go) begin
      @(negedge clk);
      aliasMatch = matchIn;
      txnStart = 1'b1;
      @(negedge clk);
      txnStart = 1'b0;
      if (lenCyc != 16'h0000) begin
         repeat (lenCyc) @(negedge clk);
         txnDone = 1'b1;
         @(negedge clk);
         txnDone = 1'b0;
      end
   end
endmodule
